/* rtl/uphr_axil.sv */
// AXI4-Lite slave front end of the pipe responder
`timescale 1ns/1ps
module uphr_axil
  import uphr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_en,
  input  wire logic        wr_ok,
  output logic             rd_en,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  `include "uphr_regs.svh"

  uphr_axil_st_t s_q;
  uphr_axil_st_t s_d;

  // Address and data are taken together, so no half-written word is ever held
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = !s_q.rvalid;
  assign wr_en         = s_axi_awready;
  assign rd_en         = s_axi_arvalid && !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  always_comb
  begin
    s_d = s_q;
    s_d.awdone = wr_en;
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (wr_en)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = wr_ok ? `UPHR_RESP_OKAY : `UPHR_RESP_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (rd_en)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_ok ? rd_data : 32'h0000_0000;
      s_d.rresp  = rd_ok ? `UPHR_RESP_OKAY : `UPHR_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

/* rtl/uphr_decide.sv */
// Answer chosen for one token from the pipe's settings and buffer state
`timescale 1ns/1ps
module uphr_decide
  import uphr_pkg::*;
(
  input  wire logic [1:0] sel,
  input  wire logic [1:0] kind,
  input  wire logic       dir,
  input  wire logic       arm,
  input  wire uphr_tok_t  tok,
  input  wire logic       oversz,
  input  wire logic       rx_ok,
  input  wire logic       rx_last,
  input  wire logic       tx_ok,
  output uphr_rsp_t       rsp,
  output logic            store,
  output logic            over
);
  `include "uphr_regs.svh"

  always_comb
  begin
    rsp   = UPHR_RSP_NONE;
    store = 1'b0;
    over  = oversz;
    case (kind)
      `UPHR_KIND_BULK, `UPHR_KIND_INTR:
      begin
        if (sel[1])
          rsp = UPHR_RSP_STALL;
        else if (sel == `UPHR_SEL_NAK)
        begin
          // Auto mode: zero-length packet on transmit, ACK on receive instead of NAK, received data is dropped
          if (!arm)
            rsp = UPHR_RSP_NAK;
          else
            rsp = dir ? UPHR_RSP_ZLP : UPHR_RSP_ACK;
        end
        else if (dir)
          rsp = tx_ok ? UPHR_RSP_DATA : UPHR_RSP_NAK;
        else if (tok == UPHR_TOK_PING)
          rsp = (kind == `UPHR_KIND_BULK && rx_ok) ? UPHR_RSP_ACK : UPHR_RSP_NAK;
        else if (tok == UPHR_TOK_OUT)
        begin
          if (oversz)
            rsp = UPHR_RSP_STALL;
          else if (rx_ok)
          begin
            store = 1'b1;
            // NYET only for bulk, interrupt always ACKs
            rsp = (kind == `UPHR_KIND_BULK && rx_last) ? UPHR_RSP_NYET : UPHR_RSP_ACK;
          end
          else
            rsp = UPHR_RSP_NAK;
        end
      end
      `UPHR_KIND_ISO:
      begin
        if (sel == `UPHR_SEL_BUF)
        begin
          if (dir)
            rsp = tx_ok ? UPHR_RSP_DATA : UPHR_RSP_ZLP;
          else if (tok == UPHR_TOK_OUT)
            store = rx_ok && !oversz;
        end
      end
      default:
        rsp = UPHR_RSP_NONE;
    endcase
  end
endmodule

/* rtl/uphr_pkg.sv */
// Types shared by the pipe responder modules
package uphr_pkg;
  typedef enum logic [1:0] {UPHR_TOK_OUT, UPHR_TOK_IN, UPHR_TOK_PING} uphr_tok_t;
  typedef enum logic [2:0] {
    UPHR_RSP_NONE, UPHR_RSP_ACK, UPHR_RSP_NYET, UPHR_RSP_NAK,
    UPHR_RSP_STALL, UPHR_RSP_DATA, UPHR_RSP_ZLP
  } uphr_rsp_t;

  typedef struct packed {
    logic        awdone;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } uphr_axil_st_t;

  typedef struct packed {
    logic [3:0][1:0]  sel;
    logic [3:0]       flush;
    logic [3:0]       tog;
    logic [3:0]       busy;
    logic [3:0][1:0]  kind;
    logic [3:0]       dir;
    logic [3:0]       arm;
    logic [3:0][10:0] mps;
    logic [1:0]       cur;
    logic             rsp_vld;
    uphr_rsp_t        rsp;
    logic             store;
    logic [1:0]       rsp_pipe;
  } uphr_st_t;
endpackage

/* rtl/uphr_regs.svh */
// Register offsets, field positions, reset values and codes of the pipe responder
// How it works
// - A bulk or interrupt pipe whose response select is NAK answers every token with NAK, unless auto response mode is set.
// - A disabled pipe, and an isochronous pipe whose response select is NAK or STALL, never answers a token.
// - A bulk receive pipe in buffer mode answers PING with ACK when its buffer can receive, else NAK.
// - An interrupt receive pipe in buffer mode takes OUT data and answers ACK when it can receive, else NAK, never NYET.
// - A bulk or interrupt transmit pipe in buffer mode sends data when its buffer holds some, else NAK.
// - An isochronous receive pipe in buffer mode stores OUT data when it can receive, else drops it, with no handshake.
// - An isochronous transmit pipe in buffer mode sends data when it holds some, else a zero-length packet.
// - A bulk or interrupt pipe whose response select is either STALL code answers every token with STALL.
// - An OUT payload above the pipe's maximum packet size forces its response select to STALL code 11.
// - A USB bus reset returns the response select of every pipe to NAK.
// - The busy flag of a pipe rises when a transaction on it begins and falls when it completes.
`ifndef UPHR_REGS_SVH
`define UPHR_REGS_SVH

`define UPHR_AW          12
`define UPHR_NPIPE       4
`define UPHR_FIRST_PIPE  4'h6
`define UPHR_LAST_PIPE   4'h9

`define UPHR_CTRL6_IDX   10'h07a
`define UPHR_CTRL7_IDX   10'h07c
`define UPHR_CTRL8_IDX   10'h07e
`define UPHR_CTRL9_IDX   10'h080
`define UPHR_CFG_BASE    12'h300
`define UPHR_CFG_STEP    12'h004

`define UPHR_SEL_LSB     0
`define UPHR_BUSY_BIT    5
`define UPHR_TOG_BIT     6
`define UPHR_TSET_BIT    7
`define UPHR_TCLR_BIT    8
`define UPHR_FLUSH_BIT   9
`define UPHR_BUF_BIT     15
`define UPHR_KIND_LSB    0
`define UPHR_DIR_BIT     4
`define UPHR_ARM_BIT     7
`define UPHR_MPS_LSB     16

`define UPHR_SEL_RST     2'h0
`define UPHR_MPS_RST     11'h200

`define UPHR_SEL_NAK     2'h0
`define UPHR_SEL_BUF     2'h1
`define UPHR_SEL_STALL10 2'h2
`define UPHR_SEL_STALL11 2'h3

`define UPHR_KIND_DIS    2'h0
`define UPHR_KIND_BULK   2'h1
`define UPHR_KIND_INTR   2'h2
`define UPHR_KIND_ISO    2'h3

`define UPHR_RESP_OKAY   2'h0
`define UPHR_RESP_SLVERR 2'h2

`endif

/* rtl/uphr_responder.sv */
// Handshake responder and control registers for pipes 6 to 9
`timescale 1ns/1ps
module uphr_responder
  import uphr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tok_valid,
  input  wire uphr_tok_t   tok_pid,
  input  wire logic [3:0]  tok_pipe,
  input  wire logic [10:0] tok_bytes,
  input  wire logic        txn_done,
  input  wire logic        bus_reset,
  input  wire logic [3:0]  buf_rx_ok,
  input  wire logic [3:0]  buf_rx_last,
  input  wire logic [3:0]  buf_tx_ok,
  output logic             rsp_valid,
  output uphr_rsp_t        rsp_code,
  output logic             rsp_store,
  output logic [3:0]       rsp_pipe,
  output logic [3:0]       pipe_busy,
  output logic [3:0]       auto_buffer_flush,
  output logic [3:0]       toggle_monitor
);
  `include "uphr_regs.svh"

  localparam logic [3:0][9:0] CTRL_IDX = {`UPHR_CTRL9_IDX, `UPHR_CTRL8_IDX,
                                          `UPHR_CTRL7_IDX, `UPHR_CTRL6_IDX};

  uphr_st_t   s_q;
  uphr_st_t   s_d;
  logic       wr_en;
  logic       rd_en;
  logic [3:0] wslot;
  logic [3:0] rslot;
  logic [31:0] rd_word;
  logic       tok_hit;
  logic [1:0] tidx;
  logic       oversz;
  uphr_rsp_t  dec_rsp;
  logic       dec_store;
  logic       dec_over;

  // Slot code: hit, config flag, pipe index; control words sit at four times the index
  function automatic logic [3:0] slot(input logic [11:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < `UPHR_NPIPE; i++)
    begin
      if (a == {CTRL_IDX[i], 2'b00})
        r = {2'b10, 2'(i)};
      if (a == `UPHR_CFG_BASE + 12'(i) * `UPHR_CFG_STEP)
        r = {2'b11, 2'(i)};
    end
    return r;
  endfunction

  assign wslot = slot(s_axi_awaddr);
  assign rslot = slot(s_axi_araddr);

  uphr_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_ok         (wslot[3]),
    .rd_en         (rd_en),
    .rd_data       (rd_word),
    .rd_ok         (rslot[3])
  );

  // Buffer flag follows the direction: receive space or sendable data
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (rslot[2])
    begin
      rd_word[`UPHR_KIND_LSB +: 2]  = s_q.kind[rslot[1:0]];
      rd_word[`UPHR_DIR_BIT]        = s_q.dir[rslot[1:0]];
      rd_word[`UPHR_ARM_BIT]        = s_q.arm[rslot[1:0]];
      rd_word[`UPHR_MPS_LSB +: 11]  = s_q.mps[rslot[1:0]];
    end
    else
    begin
      rd_word[`UPHR_SEL_LSB +: 2]   = s_q.sel[rslot[1:0]];
      rd_word[`UPHR_BUSY_BIT]       = s_q.busy[rslot[1:0]];
      rd_word[`UPHR_TOG_BIT]        = s_q.tog[rslot[1:0]];
      rd_word[`UPHR_FLUSH_BIT]      = s_q.flush[rslot[1:0]];
      rd_word[`UPHR_BUF_BIT]        = s_q.dir[rslot[1:0]] ? buf_tx_ok[rslot[1:0]]
                                                          : buf_rx_ok[rslot[1:0]];
    end
  end

  assign tok_hit = tok_valid && tok_pipe >= `UPHR_FIRST_PIPE && tok_pipe <= `UPHR_LAST_PIPE;
  assign tidx    = 2'(tok_pipe - `UPHR_FIRST_PIPE);
  assign oversz  = tok_pid == UPHR_TOK_OUT && tok_bytes > s_q.mps[tidx];

  // Decision reads the stored select at token time, so a later write waits for the next token
  uphr_decide u_decide (
    .sel     (s_q.sel[tidx]),
    .kind    (s_q.kind[tidx]),
    .dir     (s_q.dir[tidx]),
    .arm     (s_q.arm[tidx]),
    .tok     (tok_pid),
    .oversz  (oversz),
    .rx_ok   (buf_rx_ok[tidx]),
    .rx_last (buf_rx_last[tidx]),
    .tx_ok   (buf_tx_ok[tidx]),
    .rsp     (dec_rsp),
    .store   (dec_store),
    .over    (dec_over)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.rsp_vld = 1'b0;
    if (txn_done)
    begin
      s_d.busy[s_q.cur] = 1'b0;
      if (s_q.kind[s_q.cur] != `UPHR_KIND_ISO)
        s_d.tog[s_q.cur] = ~s_q.tog[s_q.cur];
    end
    // Software can write any select code; the legal STALL paths are its duty
    if (wr_en && wslot[3] && !wslot[2])
    begin
      if (s_axi_wstrb[0])
      begin
        s_d.sel[wslot[1:0]] = s_axi_wdata[`UPHR_SEL_LSB +: 2];
        if (s_axi_wdata[`UPHR_TSET_BIT])
          s_d.tog[wslot[1:0]] = 1'b1;
      end
      if (s_axi_wstrb[1])
      begin
        s_d.flush[wslot[1:0]] = s_axi_wdata[`UPHR_FLUSH_BIT];
        if (s_axi_wdata[`UPHR_TCLR_BIT])
          s_d.tog[wslot[1:0]] = 1'b0;
      end
    end
    if (wr_en && wslot[3] && wslot[2])
    begin
      if (s_axi_wstrb[0])
      begin
        s_d.kind[wslot[1:0]] = s_axi_wdata[`UPHR_KIND_LSB +: 2];
        s_d.dir[wslot[1:0]]  = s_axi_wdata[`UPHR_DIR_BIT];
        s_d.arm[wslot[1:0]]  = s_axi_wdata[`UPHR_ARM_BIT];
      end
      if (s_axi_wstrb[2])
        s_d.mps[wslot[1:0]][7:0] = s_axi_wdata[`UPHR_MPS_LSB +: 8];
      if (s_axi_wstrb[3])
        s_d.mps[wslot[1:0]][10:8] = s_axi_wdata[`UPHR_MPS_LSB + 8 +: 3];
    end
    if (tok_hit)
    begin
      s_d.cur      = tidx;
      s_d.rsp_vld  = 1'b1;
      s_d.rsp      = dec_rsp;
      s_d.store    = dec_store;
      s_d.rsp_pipe = tidx;
      // Busy set after the clear, so a new token in the done cycle is not lost
      if (dec_rsp != UPHR_RSP_NONE || dec_store)
        s_d.busy[tidx] = 1'b1;
      if (dec_over)
        s_d.sel[tidx] = `UPHR_SEL_STALL11;
    end
    // Hardware forcing comes last and wins over a software write in the same cycle
    if (bus_reset)
    begin
      for (int i = 0; i < `UPHR_NPIPE; i++)
        s_d.sel[i] = `UPHR_SEL_NAK;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      for (int i = 0; i < `UPHR_NPIPE; i++)
      begin
        s_q.sel[i] <= `UPHR_SEL_RST;
        s_q.mps[i] <= `UPHR_MPS_RST;
      end
    end
    else
      s_q <= s_d;
  end

  assign rsp_valid         = s_q.rsp_vld;
  assign rsp_code          = s_q.rsp;
  assign rsp_store         = s_q.store;
  assign rsp_pipe          = {2'b01, s_q.rsp_pipe} + 4'h2;
  assign pipe_busy         = s_q.busy;
  assign auto_buffer_flush = s_q.flush;
  assign toggle_monitor    = s_q.tog;

  logic       bi;
  logic [1:0] tk;
  logic [1:0] ts;
  assign tk = s_q.kind[tidx];
  assign ts = s_q.sel[tidx];
  assign bi = tk == `UPHR_KIND_BULK || tk == `UPHR_KIND_INTR;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_NAK: assert property (tok_hit && bi && ts == `UPHR_SEL_NAK && !s_q.arm[tidx]
    |=> rsp_valid && rsp_code == UPHR_RSP_NAK && !rsp_store)
    else $error("NAK pipe did not answer NAK");
  AST_SILENT: assert property (tok_hit && (tk == `UPHR_KIND_DIS ||
    (tk == `UPHR_KIND_ISO && ts != `UPHR_SEL_BUF))
    |=> rsp_code == UPHR_RSP_NONE && !rsp_store)
    else $error("Silent pipe answered");
  AST_BULK_OUT: assert property (tok_hit && tk == `UPHR_KIND_BULK && ts == `UPHR_SEL_BUF
    && !s_q.dir[tidx] && tok_pid == UPHR_TOK_OUT && !oversz
    |=> rsp_store == $past(buf_rx_ok[tidx]) &&
        (rsp_store ? rsp_code inside {UPHR_RSP_ACK, UPHR_RSP_NYET}
                   : rsp_code == UPHR_RSP_NAK))
    else $error("Bulk OUT answer wrong");
  AST_PING: assert property (tok_hit && tk == `UPHR_KIND_BULK && ts == `UPHR_SEL_BUF
    && !s_q.dir[tidx] && tok_pid == UPHR_TOK_PING
    |=> rsp_code == ($past(buf_rx_ok[tidx]) ? UPHR_RSP_ACK : UPHR_RSP_NAK))
    else $error("PING answer wrong");
  AST_INTR_OUT: assert property (tok_hit && tk == `UPHR_KIND_INTR && ts == `UPHR_SEL_BUF
    && !s_q.dir[tidx] && tok_pid == UPHR_TOK_OUT && !oversz
    |=> rsp_store == $past(buf_rx_ok[tidx]) &&
        rsp_code == (rsp_store ? UPHR_RSP_ACK : UPHR_RSP_NAK))
    else $error("Interrupt OUT answer wrong");
  AST_TX: assert property (tok_hit && bi && ts == `UPHR_SEL_BUF && s_q.dir[tidx]
    |=> rsp_code == ($past(buf_tx_ok[tidx]) ? UPHR_RSP_DATA : UPHR_RSP_NAK))
    else $error("Transmit answer wrong");
  AST_ISO_RX: assert property (tok_hit && tk == `UPHR_KIND_ISO && ts == `UPHR_SEL_BUF
    && !s_q.dir[tidx] && tok_pid == UPHR_TOK_OUT && !oversz
    |=> rsp_code == UPHR_RSP_NONE && rsp_store == $past(buf_rx_ok[tidx]))
    else $error("Isochronous receive wrong");
  AST_ISO_TX: assert property (tok_hit && tk == `UPHR_KIND_ISO && ts == `UPHR_SEL_BUF
    && s_q.dir[tidx]
    |=> rsp_code == ($past(buf_tx_ok[tidx]) ? UPHR_RSP_DATA : UPHR_RSP_ZLP))
    else $error("Isochronous transmit wrong");
  AST_STALL: assert property (tok_hit && bi && ts[1]
    |=> rsp_valid && rsp_code == UPHR_RSP_STALL)
    else $error("STALL pipe did not stall");
  AST_OVER: assert property (tok_hit && oversz && !bus_reset
    |=> s_q.sel[$past(tidx)] == `UPHR_SEL_STALL11)
    else $error("Oversize packet did not force STALL");
  AST_BUSRST: assert property (bus_reset
    |=> (s_q.sel == '0 and (!tok_hit && !wr_en |=> s_q.sel == '0)))
    else $error("Bus reset left a select not NAK");
  AST_BUSY: assert property (txn_done && !(tok_hit && tidx == s_q.cur)
    |=> !pipe_busy[$past(s_q.cur)])
    else $error("Busy not cleared on completion");
  AST_HOLD: assert property (!tok_hit |=> $stable(rsp_code) && $stable(rsp_store))
    else $error("Answer changed without a token");

  COV_NYET: cover property (rsp_valid && rsp_code == UPHR_RSP_NYET);
  COV_ZLP: cover property (rsp_valid && rsp_code == UPHR_RSP_ZLP);
  COV_OVER: cover property (tok_hit && oversz ##1 rsp_code == UPHR_RSP_STALL);
  COV_BUSY: cover property (tok_hit ##[1:8] txn_done);
endmodule

/* verif/tb.sv */
// Self-checking bench for the pipe responder
`timescale 1ns/1ps
`include "uphr_regs.svh"
module tb
  import uphr_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, tok_valid, txn_done, bus_reset;
  logic        rsp_valid, rsp_store, seen;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, tok_pipe, buf_rx_ok, buf_rx_last, buf_tx_ok, rsp_pipe;
  logic [3:0]  pipe_busy, auto_buffer_flush, toggle_monitor;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [10:0] tok_bytes;
  uphr_tok_t   tok_pid;
  uphr_rsp_t   rsp_code;
  int          num_errors, comparisons, k, d, a, i, t, b;
  int          sq[4] = '{0, 1, 3, 2};

  uphr_responder DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tok_valid, .tok_pid, .tok_pipe,
    .tok_bytes, .txn_done, .bus_reset, .buf_rx_ok, .buf_rx_last, .buf_tx_ok, .rsp_valid,
    .rsp_code, .rsp_store, .rsp_pipe, .pipe_busy, .auto_buffer_flush, .toggle_monitor);

  uphr_host_model host (.aclk, .tok_valid, .tok_pid, .tok_pipe, .tok_bytes, .txn_done,
    .bus_reset, .rsp_valid);

  always #20 aclk = ~aclk;

  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input bit ok);
    if (!ok)
    begin
      num_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, 0, 1);
      test_done();
    end
  endtask

  function automatic logic [11:0] ca(int n);
    return {`UPHR_CTRL6_IDX + 10'(2 * n), 2'b00};
  endfunction

  function automatic logic [11:0] cfg(int n);
    return `UPHR_CFG_BASE + `UPHR_CFG_STEP * 12'(n);
  endfunction

  // Write with address and data offered together; each released when taken
  task automatic axw(input logic [11:0] ad, input logic [31:0] dt, input logic [1:0] er);
    int n;
    bit v = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !v; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        v = 1'b1;
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
      end
    end
    tmo(v);
  endtask

  task automatic axr(input logic [11:0] ad, output logic [31:0] dt, input logic [1:0] er);
    int n;
    bit v = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !v; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        v = 1'b1;
        dt = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, er);
      end
    end
    tmo(v);
  endtask

  // Expected {store, answer} for one token; b is 0 empty, 1 ready, 2 ready on last space
  function automatic logic [3:0] expr(int k, int d, int a, int s, int t, int b);
    uphr_rsp_t r = UPHR_RSP_NONE;
    logic      st = 1'b0;
    bit        ok = b != 0;
    if (k == 0) ;
    else if (k == 3) begin if (s == 1 && d) r = ok ? UPHR_RSP_DATA : UPHR_RSP_ZLP;
      else if (s == 1) st = ok; end
    else if (s >= 2) r = UPHR_RSP_STALL;
    else if (s == 0) r = a ? (d ? UPHR_RSP_ZLP : UPHR_RSP_ACK) : UPHR_RSP_NAK;
    else if (d) r = ok ? UPHR_RSP_DATA : UPHR_RSP_NAK;
    else if (t == 2) r = (ok && k == 1) ? UPHR_RSP_ACK : UPHR_RSP_NAK;
    else begin r = !ok ? UPHR_RSP_NAK : (k == 1 && b == 2) ? UPHR_RSP_NYET : UPHR_RSP_ACK;
      st = ok; end
    return {st, r};
  endfunction

  task automatic try_tok(int k, int d, int a, int s, int t, int b);
    logic [3:0] e;
    e = expr(k, d, a, s, t, b);
    @(posedge aclk);
    buf_rx_ok <= {4{b != 0}};
    buf_tx_ok <= {4{b != 0}};
    buf_rx_last <= {4{b == 2}};
    host.token(uphr_tok_t'(t), 4'h7, 11'd8, seen);
    chk({seen, rsp_store, rsp_code, rsp_pipe}, {1'b1, e, 4'h7});
    chk(pipe_busy[1], e[3] || e[2:0] != 3'h0);
    host.done();
    chk(pipe_busy, 4'h0);
  endtask

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, buf_rx_ok, buf_rx_last, buf_tx_ok} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      axr(ca(i), rd, 2'h0);
      chk(rd, 32'h0);
      axr(cfg(i), rd, 2'h0);
      chk(rd, 32'h0200_0000);
    end
    $display("reset values done");
    for (k = 0; k < 4; k++)
      for (d = 0; d < 2; d++)
        for (a = 0; a < 2; a++)
        begin
          axw(ca(1), 32'h0, 2'h0);
          axw(cfg(1), 32'h0200_0000 | 32'(a << 7 | d << 4 | k), 2'h0);
          // Select order 0,1,3,2 keeps each step a permitted move
          for (i = 0; i < 4; i++)
          begin
            axw(ca(1), 32'(sq[i]), 2'h0);
            for (t = 0; t < 3; t++)
              for (b = 0; b < 3; b++)
                if (!(d ? t != 1 : (t == 1 || (k == 3 && t == 2))))
                  try_tok(k, d, a, sq[i], t, b);
          end
        end
    $display("response table done");
    axw(cfg(0), 32'h0008_0001, 2'h0);
    axw(ca(0), 32'h1, 2'h0);
    @(posedge aclk);
    buf_rx_ok <= 4'hf;
    buf_rx_last <= 4'h0;
    host.token(UPHR_TOK_OUT, 4'h6, 11'd8, seen);
    chk({rsp_store, rsp_code}, {1'b1, UPHR_RSP_ACK});
    host.done();
    host.token(UPHR_TOK_OUT, 4'h6, 11'd9, seen);
    chk(rsp_code, UPHR_RSP_STALL);
    host.done();
    axr(ca(0), rd, 2'h0);
    chk(rd[1:0], 2'h3);
    axw(ca(0), 32'h2, 2'h0);
    axw(ca(0), 32'h0, 2'h0);
    axr(ca(0), rd, 2'h0);
    chk(rd[15:0], 16'h8000);
    host.token(UPHR_TOK_OUT, 4'h6, 11'd8, seen);
    axw(ca(0), 32'h1, 2'h0);
    chk(rsp_code, UPHR_RSP_NAK);
    host.done();
    host.token(UPHR_TOK_OUT, 4'h6, 11'd8, seen);
    chk({rsp_store, rsp_code, rsp_pipe}, {1'b1, UPHR_RSP_ACK, 4'h6});
    host.done();
    $display("oversize done");
    for (i = 1; i < 4; i++)
      axw(ca(i), 32'h1, 2'h0);
    host.token(UPHR_TOK_OUT, 4'h5, 11'd8, seen);
    chk(seen, 1'b0);
    host.breset();
    for (i = 0; i < 4; i++)
    begin
      axr(ca(i), rd, 2'h0);
      chk(rd[1:0], 2'h0);
    end
    axw(12'h010, 32'h1, 2'h2);
    axr(12'h010, rd, 2'h2);
    $display("bus reset done");
    axw(ca(2), 32'h280, 2'h0);
    @(negedge aclk);
    chk({auto_buffer_flush[2], toggle_monitor[2]}, 2'b11);
    axr(ca(2), rd, 2'h0);
    chk(rd[9:0], 10'h240);
    axw(ca(2), 32'h100, 2'h0);
    @(negedge aclk);
    chk({auto_buffer_flush[2], toggle_monitor[2]}, 2'b00);
    // Only byte lane 1 is written, so the select must keep its old value
    @(posedge aclk);
    s_axi_wstrb <= 4'h2;
    axw(ca(2), 32'h203, 2'h0);
    s_axi_wstrb <= 4'hf;
    axr(ca(2), rd, 2'h0);
    chk(rd[9:0], 10'h200);
    $display("toggle bits done");
    test_done();
  end
endmodule

/* verif/uphr_host_model.sv */
// Host-side token source facing the pipe responder
`timescale 1ns/1ps
module uphr_host_model
  import uphr_pkg::*;
(
  input  wire logic  aclk,
  output logic       tok_valid,
  output uphr_tok_t  tok_pid,
  output logic [3:0] tok_pipe,
  output logic [10:0] tok_bytes,
  output logic       txn_done,
  output logic       bus_reset,
  input  wire logic  rsp_valid
);
  initial
  begin
    {tok_valid, txn_done, bus_reset, tok_pipe, tok_bytes} = '0;
    tok_pid = UPHR_TOK_OUT;
  end

  // Fields are inverted once the token is gone, so stale values are never trusted
  task automatic token(input uphr_tok_t p, input logic [3:0] n, input logic [10:0] b,
                       output logic seen);
    @(posedge aclk);
    tok_valid <= 1'b1;
    tok_pid <= p;
    tok_pipe <= n;
    tok_bytes <= b;
    @(posedge aclk);
    tok_valid <= 1'b0;
    tok_pid <= uphr_tok_t'(~p);
    tok_pipe <= ~n;
    tok_bytes <= ~b;
    @(negedge aclk);
    seen = rsp_valid;
  endtask

  task automatic done();
    @(posedge aclk);
    txn_done <= 1'b1;
    @(posedge aclk);
    txn_done <= 1'b0;
    @(negedge aclk);
  endtask

  task automatic breset();
    @(posedge aclk);
    bus_reset <= 1'b1;
    @(posedge aclk);
    bus_reset <= 1'b0;
    @(negedge aclk);
  endtask
endmodule
